// [rtl/tmc_out_uin_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - timed output lasts its time
// - 10 ms or 100 ms steps
// - normal output on at preset
// - reversal inverts output
// - lamp has own reversal
// - power-up off, on or previous (latched modes only)
// - freeze holds display only
// - level freeze-reset holds timer
// - edge freeze-reset pulses reset
// - level reset holds all reset
// - edge reset pulses all reset
// - change-display edge steps display
// - first input selects down
// - print input requests print
// - output reset edge clears once
// - stopped timer restarts after reset
// - down on input one only
// - program disable is level
// - code selects menu access
// - scroll every 2.5 s
// - baud and parity framing
module tmc_out_uin_ctrl #(
   parameter int unsigned STEP_CYC = tmc_pkg::STEP_FINE_CYC, // cycles per 10 ms step
   parameter int unsigned DEB_CYC = tmc_pkg::DEBOUNCE_CYC, // debounce cycles
   parameter int unsigned CLK_HZ = tmc_pkg::SYS_CLK_HZ, // feeds the baud divisors
   parameter int unsigned DISP_VALUES = tmc_pkg::DISP_VALUES_DEF // secondary values
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [tmc_pkg::NUM_IN-1:0] user_in_pin,
   input wire logic [tmc_pkg::NUM_OUT-1:0] preset_hit,
   input wire logic [tmc_pkg::NUM_OUT-1:0] timed_out_mode,
   input wire logic [tmc_pkg::NUM_OUT-1:0] latched_out_mode,
   input wire logic [tmc_pkg::NUM_OUT-1:0] prev_out_state,
   input wire logic timer_stopped,
   input wire logic [7:0] code_entry,
   input wire logic code_entry_valid,
   output logic [tmc_pkg::NUM_OUT-1:0] out_relay,
   output logic [tmc_pkg::NUM_OUT-1:0] out_annun,
   output logic timer_reset,
   output logic timer_restart,
   output logic display_freeze,
   output logic count_direction_input,
   output logic [tmc_pkg::DISP_W-1:0] next_display_value,
   output logic print_request,
   output logic [1:0] print_selection,
   output logic prog_disabled,
   output logic code_entry_offered,
   output tmc_pkg::tmc_access_t menu_access,
   output logic baud_tick,
   output logic serial_data_8,
   output logic serial_parity_en,
   output logic serial_parity_odd
);
   import tmc_pkg::*;

   // ====================
   // register file
   logic [31:0] ctrl_q; // control word
   logic [15:0] infn_q; // input functions
   logic [TIME_W-1:0] time_q [NUM_OUT]; // output times in steps
   logic [7:0] code_q; // security code
   logic [31:0] rdata_q; // read answer, one cycle late
   tmc_ctrl_t ctrl; // field view of the control word

   assign ctrl = tmc_ctrl_t'(ctrl_q);

   // address decode
   wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
   wire wr_infn = reg_wr && (reg_addr == REG_INFN);
   wire wr_time0 = reg_wr && (reg_addr == REG_TIME0);
   wire wr_time1 = reg_wr && (reg_addr == REG_TIME1);
   wire wr_code = reg_wr && (reg_addr == REG_CODE);

   // live state words
   logic [31:0] stat_word; // status bits
   logic [31:0] rd_mux; // selected read value

   // unmapped addresses read as zero
   always_comb begin
      if (reg_addr == REG_CTRL) begin
         rd_mux = ctrl_q;
      end else if (reg_addr == REG_INFN) begin
         rd_mux = {16'h0, infn_q};
      end else if (reg_addr == REG_TIME0) begin
         rd_mux = {18'h0, time_q[0]};
      end else if (reg_addr == REG_TIME1) begin
         rd_mux = {18'h0, time_q[1]};
      end else if (reg_addr == REG_CODE) begin
         rd_mux = {24'h0, code_q};
      end else if (reg_addr == REG_STAT) begin
         rd_mux = stat_word;
      end else begin
         rd_mux = 32'h0;
      end
   end

   // writes land at the strobe; reads answer a cycle later
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= CTRL_RST;
         infn_q <= INFN_RST;
         time_q[0] <= TIME_RST;
         time_q[1] <= TIME_RST;
         code_q <= CODE_RST;
         rdata_q <= 32'h0;
      end else begin
         if (wr_ctrl) ctrl_q <= {16'h0, reg_wdata[15:0]};
         if (wr_infn) infn_q <= reg_wdata[15:0];
         if (wr_time0) time_q[0] <= reg_wdata[TIME_W-1:0];
         if (wr_time1) time_q[1] <= reg_wdata[TIME_W-1:0];
         if (wr_code) code_q <= reg_wdata[7:0];
         rdata_q <= reg_rd ? rd_mux : 32'h0;
      end
   end

   assign reg_rdata = rdata_q;

   // ====================
   // 10 ms and 100 ms enables
   logic [31:0] fine_cnt_q; // cycle divider
   logic [3:0] coarse_cnt_q; // fine steps per coarse step
   wire fine_tick = fine_cnt_q == (STEP_CYC - 1);
   wire coarse_tick = fine_tick && (coarse_cnt_q == 4'(FINE_PER_COARSE - 1));
   // one setting for all outputs
   wire step_tick = ctrl.output_resolution_select ? coarse_tick : fine_tick;

   // free-running dividers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fine_cnt_q <= 32'h0;
         coarse_cnt_q <= 4'h0;
      end else begin
         fine_cnt_q <= fine_tick ? 32'h0 : fine_cnt_q + 1'b1;
         if (coarse_tick) begin
            coarse_cnt_q <= 4'h0;
         end else if (fine_tick) begin
            coarse_cnt_q <= coarse_cnt_q + 1'b1;
         end
      end
   end

   // ====================
   // user inputs: filter, then decode
   logic [NUM_IN-1:0] in_lvl; // debounced levels
   logic [NUM_IN-1:0] in_rise; // debounced activation edges
   tmc_fn_t in_fn_raw [NUM_IN]; // function as written
   tmc_fn_t in_fn [NUM_IN]; // function after position limits
   logic [NUM_IN-1:0] frz_v, hold_v, pulse_v, orst_v, next_v, pdis_v, prn_v;

   for (genvar i = 0; i < NUM_IN; i++) begin : g_in
      // one activation gives exactly one edge
      tmc_debounce #(.CYC(DEB_CYC)) u_deb (
         .sys_clk(sys_clk),
         .rst_b(rst_b),
         .pin_in(user_in_pin[i]),
         .level(in_lvl[i]),
         .rise(in_rise[i])
      );
      assign in_fn_raw[i] = tmc_fn_t'(infn_q[4*i +: 4]);
      // refused placements act as none
      assign in_fn[i] = (((in_fn_raw[i] == FN_COUNT_DIR) && (i != 0)) ||
                         ((in_fn_raw[i] == FN_PROG_DIS) && (i == KEY_IDX))) ?
                        FN_NONE : in_fn_raw[i];
      // display freeze while the input is held
      assign frz_v[i] = in_lvl[i] && ((in_fn[i] == FN_FREEZE) ||
                        (in_fn[i] == FN_FREEZE_AND_RESET_LVL) ||
                        (in_fn[i] == FN_FREEZE_AND_RESET_EDGE));
      // timer held at reset while active
      assign hold_v[i] = in_lvl[i] && ((in_fn[i] == FN_FREEZE_AND_RESET_LVL) ||
                         (in_fn[i] == FN_RST_LVL));
      // one-cycle timer reset at activation
      assign pulse_v[i] = in_rise[i] && ((in_fn[i] == FN_FREEZE_AND_RESET_EDGE) ||
                          (in_fn[i] == FN_RST_EDGE));
      // output clear: level, edge or output reset
      assign orst_v[i] = (in_lvl[i] && (in_fn[i] == FN_RST_LVL)) ||
                         (in_rise[i] && ((in_fn[i] == FN_RST_EDGE) ||
                          (in_fn[i] == FN_OUT_RESET)));
      assign next_v[i] = in_rise[i] && (in_fn[i] == FN_NEXT_DISP);
      assign pdis_v[i] = in_lvl[i] && (in_fn[i] == FN_PROG_DIS);
      assign prn_v[i] = in_lvl[i] && (in_fn[i] == FN_PRINT);
   end

   // several freeze inputs just OR; unsupported setup
   wire freeze_any = |frz_v;
   wire hold_any = |hold_v;
   wire pulse_any = |pulse_v;
   wire out_clear = |orst_v;
   wire down_sel = in_lvl[0] && (in_fn[0] == FN_COUNT_DIR);

   // ====================
   // timer control strobes
   logic hold_any_q; // previous hold level, for release detection
   logic timer_reset_q, timer_restart_q, freeze_q, down_q, print_q, pdis_q;
   // level resets restart on release, edge resets at once
   wire restart_d = timer_stopped && (pulse_any || (hold_any_q && !hold_any));

   // registered control outputs
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         hold_any_q <= 1'b0;
         timer_reset_q <= 1'b0;
         timer_restart_q <= 1'b0;
         freeze_q <= 1'b0;
         down_q <= 1'b0;
         print_q <= 1'b0;
         pdis_q <= 1'b0;
      end else begin
         hold_any_q <= hold_any;
         timer_reset_q <= hold_any || pulse_any;
         timer_restart_q <= restart_d;
         freeze_q <= freeze_any;
         down_q <= down_sel;
         print_q <= |prn_v;
         pdis_q <= |pdis_v;
      end
   end

   assign timer_reset = timer_reset_q;
   assign timer_restart = timer_restart_q;
   assign display_freeze = freeze_q;
   assign count_direction_input = down_q;
   assign print_request = print_q;
   assign print_selection = ctrl.print_selection;
   assign prog_disabled = pdis_q;

   // ====================
   // outputs
   logic pwr_init_q; // first cycle after release
   logic [NUM_OUT-1:0] act_q; // logical active state per output

   // power-up state applied once after release
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pwr_init_q <= 1'b1;
      end else begin
         pwr_init_q <= 1'b0;
      end
   end

   for (genvar j = 0; j < NUM_OUT; j++) begin : g_out
      logic [TIME_W-1:0] cnt_q; // remaining steps
      // previous state only counts in latched modes
      wire pwr_on = (ctrl.pwr_up[j] == PWR_ON) ||
                    ((ctrl.pwr_up[j] == PWR_PREV) && latched_out_mode[j] &&
                     prev_out_state[j]);
      wire run = timed_out_mode[j] && act_q[j] && step_tick;

      // reset beats a same-cycle preset
      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            act_q[j] <= 1'b0;
            cnt_q <= '0;
         end else if (pwr_init_q) begin
            act_q[j] <= pwr_on;
            cnt_q <= time_q[j];
         end else if (out_clear) begin
            act_q[j] <= 1'b0;
         end else if (preset_hit[j]) begin
            act_q[j] <= 1'b1;
            cnt_q <= time_q[j];
         end else if (run) begin
            // last step ends the timed pulse
            if (cnt_q <= TIME_W'(1)) begin
               act_q[j] <= 1'b0;
            end
            cnt_q <= (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
         end
      end

      // relay and lamp each have a flip
      assign out_relay[j] = act_q[j] ^ ctrl.rev_out[j];
      assign out_annun[j] = out_relay[j] ^ ctrl.rev_ann[j];
   end

   // ====================
   // secondary display sequencing
   logic [DISP_W-1:0] disp_q; // current secondary value index
   logic [8:0] scroll_cnt_q; // fine steps since last advance
   wire scroll_adv = ctrl.scroll_en && fine_tick &&
                     (scroll_cnt_q == 9'(SCROLL_STEPS - 1));
   wire disp_adv = (|next_v) || scroll_adv;
   wire disp_last = disp_q == DISP_W'(DISP_VALUES - 1);

   // a manual step also restarts the scroll period
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         disp_q <= '0;
         scroll_cnt_q <= 9'h000;
      end else begin
         if (!ctrl.scroll_en || disp_adv) begin
            scroll_cnt_q <= 9'h000;
         end else if (fine_tick) begin
            scroll_cnt_q <= scroll_cnt_q + 1'b1;
         end
         if (disp_adv) begin
            disp_q <= disp_last ? '0 : disp_q + 1'b1;
         end
      end
   end

   assign next_display_value = disp_q;

   // ====================
   // programming access
   tmc_access_t acc_q; // granted menu level
   wire code_prot = (code_q >= CODE_PROT_MIN) && (code_q <= CODE_PROT_MAX);
   wire code_prog = (code_q >= CODE_PROG_MIN) && (code_q <= CODE_PROG_MAX);
   wire code_ok = code_entry_valid && (code_q != 8'h00) && (code_entry == code_q);

   // a grant lasts until program disable is released
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_q <= ACC_OPEN;
      end else if (!pdis_q) begin
         acc_q <= ACC_OPEN;
      end else if (code_ok && code_prog) begin
         acc_q <= ACC_PROG;
      end else if (code_ok && code_prot) begin
         acc_q <= ACC_PROT;
      end else if (acc_q == ACC_OPEN) begin
         acc_q <= ACC_LOCKED;
      end
   end

   assign menu_access = acc_q;
   assign code_entry_offered = pdis_q && (code_q != 8'h00);

   // ====================
   // serial rate and framing
   logic [BAUD_DIV_W-1:0] baud_cnt_q; // bit-time divider
   logic baud_tick_q; // one-cycle bit enable
   logic [BAUD_DIV_W-1:0] baud_div; // selected divisor

   // divisors derive from the clock parameter
   always_comb begin
      case (ctrl.baud)
         BR_1200: baud_div = BAUD_DIV_W'(CLK_HZ / BAUD_A);
         BR_2400: baud_div = BAUD_DIV_W'(CLK_HZ / BAUD_B);
         BR_4800: baud_div = BAUD_DIV_W'(CLK_HZ / BAUD_C);
         default: baud_div = BAUD_DIV_W'(CLK_HZ / BAUD_D);
      endcase
   end

   wire baud_wrap = baud_cnt_q >= (baud_div - 1'b1);

   // a rate change mid-count settles within one bit time
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         baud_cnt_q <= '0;
         baud_tick_q <= 1'b0;
      end else begin
         baud_cnt_q <= baud_wrap ? '0 : baud_cnt_q + 1'b1;
         baud_tick_q <= baud_wrap;
      end
   end

   assign baud_tick = baud_tick_q;
   // parity framing uses 7 data bits, none uses 8
   assign serial_data_8 = ctrl.parity == PAR_NONE;
   assign serial_parity_en = ctrl.parity != PAR_NONE;
   assign serial_parity_odd = ctrl.parity == PAR_ODD;

   // ====================
   // status word
   assign stat_word = {18'h0, acc_q, disp_q, pdis_q, print_q, down_q,
                       timer_reset_q, freeze_q, out_annun, out_relay};
endmodule
`default_nettype wire

// [rtl/tmc_pkg.sv]
package tmc_pkg;
   // ====================
   // register map, byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00; // control fields, tmc_ctrl_t
   localparam logic [7:0] REG_INFN = 8'h04; // four input functions, 4 bits each
   localparam logic [7:0] REG_TIME0 = 8'h08; // output 0 time in steps
   localparam logic [7:0] REG_TIME1 = 8'h0C; // output 1 time in steps
   localparam logic [7:0] REG_CODE = 8'h10; // security code 0..199
   localparam logic [7:0] REG_STAT = 8'h14; // read-only live state

   // ====================
   // sizes
   localparam int NUM_IN = 4; // three pins plus the front key
   localparam int KEY_IDX = 3; // front key position
   localparam int NUM_OUT = 2; // two preset outputs
   localparam int TIME_W = 14; // 9999 steps fit
   localparam int DISP_VALUES_DEF = 4; // secondary display choices
   localparam int DISP_W = 3; // width of the display index

   // ====================
   // timing
   localparam int SYS_CLK_HZ = 100_000_000;
   localparam int STEP_FINE_MS = 10;
   localparam int STEP_FINE_CYC = SYS_CLK_HZ / 1000 * STEP_FINE_MS;
   localparam int STEP_COARSE_MS = 100;
   localparam int FINE_PER_COARSE = STEP_COARSE_MS / STEP_FINE_MS;
   localparam int SCROLL_MS = 2500;
   localparam int SCROLL_STEPS = SCROLL_MS / STEP_FINE_MS;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYC = SYS_CLK_HZ / 1000 * DEBOUNCE_MS;
   localparam int BAUD_A = 1200;
   localparam int BAUD_B = 2400;
   localparam int BAUD_C = 4800;
   localparam int BAUD_D = 9600;
   localparam int BAUD_DIV_W = 20; // holds the slowest divisor

   // ====================
   // security code ranges
   localparam logic [7:0] CODE_PROT_MIN = 8'h01;
   localparam logic [7:0] CODE_PROT_MAX = 8'h63;
   localparam logic [7:0] CODE_PROG_MIN = 8'h64;
   localparam logic [7:0] CODE_PROG_MAX = 8'hC7;

   // ====================
   // enumerations
   typedef enum logic [3:0] {
      FN_NONE, FN_FREEZE, FN_FREEZE_AND_RESET_LVL, FN_FREEZE_AND_RESET_EDGE,
      FN_RST_LVL, FN_RST_EDGE, FN_NEXT_DISP, FN_PROG_DIS, FN_COUNT_DIR,
      FN_PRINT, FN_OUT_RESET
   } tmc_fn_t;
   typedef enum logic [1:0] {PWR_OFF, PWR_ON, PWR_PREV} tmc_pwr_t;
   typedef enum logic [1:0] {BR_1200, BR_2400, BR_4800, BR_9600} tmc_baud_t;
   typedef enum logic [1:0] {PAR_NONE, PAR_ODD, PAR_EVEN} tmc_par_t;
   typedef enum logic [1:0] {ACC_OPEN, ACC_LOCKED, ACC_PROT, ACC_PROG} tmc_access_t;

   // ====================
   // control register layout, lsb last
   typedef struct packed {
      logic [15:0] rsvd;
      logic [1:0] print_selection;
      tmc_par_t parity;
      tmc_baud_t baud;
      logic scroll_en;
      tmc_pwr_t [NUM_OUT-1:0] pwr_up;
      logic [NUM_OUT-1:0] rev_ann;
      logic [NUM_OUT-1:0] rev_out;
      logic output_resolution_select;
   } tmc_ctrl_t;

   // ====================
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000CC00; // 9600 none, print both
   localparam logic [15:0] INFN_RST = {4{FN_RST_LVL}};
   localparam logic [TIME_W-1:0] TIME_RST = 14'h000A; // 0.10 s
   localparam logic [7:0] CODE_RST = 8'h00;
endpackage

// [rtl/tmc_debounce.sv]
`timescale 1ns/10ps
`default_nettype none
module tmc_debounce #(
   parameter int unsigned CYC = 4 // stable cycles before a change counts
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic pin_in,
   output logic level,
   output logic rise
);
   localparam int CW = $clog2(CYC + 1);

   logic [2:0] sync_q; // three-stage synchroniser
   logic [CW-1:0] cnt_q; // stability counter
   logic level_q; // filtered level
   logic rise_q; // one-cycle activation pulse

   // ====================
   // stages two and three must agree
   wire agree = sync_q[1] == sync_q[2];
   wire moved = agree && (sync_q[2] != level_q);
   wire done = moved && (cnt_q == CW'(CYC - 1));

   // sampling and filter; a bounce restarts the count
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_q <= 3'h0;
         cnt_q <= '0;
         level_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         sync_q <= {sync_q[1:0], pin_in};
         cnt_q <= (moved && !done) ? cnt_q + 1'b1 : '0;
         rise_q <= done && sync_q[2];
         if (done) begin
            level_q <= sync_q[2];
         end
      end
   end

   assign level = level_q;
   assign rise = rise_q;
endmodule
`default_nettype wire

// [rtl/_unused_placeholder_none.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [tb/tmc_props.sv]
`timescale 1ns/10ps
`default_nettype none
// =====================================
// port checks
module tmc_props #(
   parameter int unsigned DISP_VALUES = tmc_pkg::DISP_VALUES_DEF // display choices
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic reg_wr,
   input wire logic timer_stopped,
   input wire logic [tmc_pkg::NUM_OUT-1:0] out_relay,
   input wire logic [tmc_pkg::NUM_OUT-1:0] out_annun,
   input wire logic timer_restart,
   input wire logic [tmc_pkg::DISP_W-1:0] next_display_value,
   input wire logic baud_tick,
   input wire logic serial_data_8,
   input wire logic serial_parity_en,
   input wire logic prog_disabled,
   input wire logic code_entry_offered,
   input wire tmc_pkg::tmc_access_t menu_access
);
   import tmc_pkg::*;
   // =====================================
   // one clock, one reset
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   // relay and lamp differ by a register bit, moved only by a write
   a_annun_pair: assert property (!$past(reg_wr) |->
      (out_relay ^ out_annun) == $past(out_relay ^ out_annun))
      else $error("lamp drifted from relay");
   a_disp_step: assert property ($changed(next_display_value) |->
      next_display_value == DISP_W'(($past(next_display_value) + 1) % DISP_VALUES))
      else $error("display index skipped");
   // fastest rate is ten clocks a bit here
   a_baud_gap: assert property (baud_tick |=> !baud_tick [*8])
      else $error("bit ticks too close");
   a_data_bits: assert property (serial_data_8 != serial_parity_en)
      else $error("data bits mismatch parity");
   a_restart_one: assert property (timer_restart |=> !timer_restart)
      else $error("restart too long");
   a_restart_cause: assert property (timer_restart |-> $past(timer_stopped))
      else $error("restart while running");
   a_code_offer: assert property (code_entry_offered |-> prog_disabled)
      else $error("code offered while unlocked");
   a_access_open: assert property (!prog_disabled [*2] |-> menu_access == ACC_OPEN)
      else $error("restricted without disable");
   a_grant_needs: assert property (menu_access inside {ACC_PROT, ACC_PROG} |-> $past(prog_disabled))
      else $error("grant without disable");
endmodule
`default_nettype wire

// [tb/tmc_far_model.sv]
`timescale 1ns/10ps
`default_nettype none
// =====================================
// far side: chattering switch contacts
module tmc_far_model (
   input wire logic sys_clk,
   input wire logic [tmc_pkg::NUM_IN-1:0] press,
   output logic [tmc_pkg::NUM_IN-1:0] user_in_pin
);
   import tmc_pkg::*;
   logic [NUM_IN-1:0] last_q = '0; // contact position a clock ago
   logic [1:0] chat_q = 2'h0; // chatter clocks still to come
   initial user_in_pin = '0;
   // one-clock bounces, far shorter than the filter
   always @(posedge sys_clk) begin
      last_q <= press;
      if (press != last_q) begin
         chat_q <= 2'h3;
      end else if (chat_q != 2'h0) begin
         chat_q <= chat_q - 2'h1;
      end
      user_in_pin <= chat_q[0] ? ~press : press;
   end
endmodule
`default_nettype wire

// [tb/tb_tmc_out_uin_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
// =====================================
// bench: register calls and pin presses
module tb_tmc_out_uin_ctrl;
   import tmc_pkg::*;
   logic sys_clk, rst_b, reg_wr, reg_rd, code_entry_valid, timer_stopped, timer_reset, timer_restart;
   logic display_freeze, count_direction_input, print_request, prog_disabled, code_entry_offered;
   logic baud_tick, serial_data_8, serial_parity_en, serial_parity_odd;
   logic [7:0] reg_addr, code_entry;
   logic [31:0] reg_wdata, reg_rdata;
   logic [NUM_IN-1:0] press, user_in_pin;
   logic [NUM_OUT-1:0] preset_hit, timed_out_mode, latched_out_mode, prev_out_state, out_relay, out_annun;
   logic [DISP_W-1:0] next_display_value, d;
   logic [1:0] print_selection;
   tmc_access_t menu_access;
   int err_count, num_checks, rst_hits, restarts, h0, r0, n;
   // function, input, status [8:4]
   int fn_tab [10] = '{1, 2, 3, 4, 5, 8, 8, 9, 7, 7};
   int idx_tab [10] = '{0, 0, 0, 0, 0, 0, 1, 2, 2, 3};
   logic [4:0] exp_tab [10] = '{5'h01, 5'h03, 5'h01, 5'h02, 5'h00, 5'h04, 5'h00, 5'h08, 5'h10, 5'h00};
   logic [7:0] code_tab [3] = '{8'h00, 8'h32, 8'h96};
   tmc_access_t acc_tab [3] = '{ACC_LOCKED, ACC_PROT, ACC_PROG};
   int rate_tab [4] = '{BAUD_A, BAUD_B, BAUD_C, BAUD_D};
   logic [2:0] fmt_tab [3] = '{3'h4, 3'h3, 3'h2};
   // short step and filter keep the run small
   tmc_out_uin_ctrl #(.STEP_CYC(10), .DEB_CYC(4), .CLK_HZ(96000)) dut_u (.*);
   tmc_far_model far_u (.sys_clk(sys_clk), .press(press), .user_in_pin(user_in_pin));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // tallies tell edge functions from level ones
   always @(posedge sys_clk) begin
      rst_hits <= rst_hits + int'(timer_reset);
      restarts <= restarts + int'(timer_restart);
   end
   // =====================================
   // access tasks
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      chk("reg_rdata", exp, reg_rdata & m);
   endtask
   // chatter, sync, filter and two registers fit in 15 clocks
   task hold(input int i, input logic v);
      press[i] <= v;
      repeat (15) @(posedge sys_clk);
   endtask
   task tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task fire(input logic [1:0] m);
      preset_hit <= m;
      @(posedge sys_clk);
      preset_hit <= 2'h0;
   endtask
   task code_in(input logic [7:0] c);
      code_entry <= c;
      code_entry_valid <= 1'b1;
      @(posedge sys_clk);
      code_entry_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask
   task gap(output int k);
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (baud_tick !== 1'b1 && k < 200);
   endtask
   task close_out;
      if (err_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // run takes about 4000 clocks
   initial begin
      #250us;
      err_count++;
      close_out();
   end
   initial begin
      {rst_b, reg_wr, reg_rd, code_entry_valid, timer_stopped, reg_addr, code_entry, reg_wdata} = '0;
      {press, preset_hit, timed_out_mode, latched_out_mode, prev_out_state} = '0;
      {err_count, num_checks, rst_hits, restarts} = '0;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rd(REG_CTRL, CTRL_RST);
      rd(REG_INFN, 32'(INFN_RST));
      rd(8'h18, 32'h0);
      chk("print_selection", CTRL_RST[15:14], print_selection);
      timer_stopped <= 1'b1;
      // one input carries a function at a time
      for (int i = 0; i < 10; i++) begin
         h0 = rst_hits;
         r0 = restarts;
         wr(REG_INFN, 32'(fn_tab[i]) << (4 * idx_tab[i]));
         hold(idx_tab[i], 1'b1);
         rd(REG_STAT, {23'h0, exp_tab[i], 4'h0}, 32'h1F0);
         hold(idx_tab[i], 1'b0);
         if (i == 2 || i == 4) chk("reset pulses", 1, rst_hits - h0);
         if (i > 0 && i < 5) chk("restarts", 1, restarts - r0);
      end
      timer_stopped <= 1'b0;
      timed_out_mode <= 2'h1;
      wr(REG_TIME0, 32'h3);
      fire(2'h3);
      tick(15);
      chk("out_relay", 2'h3, out_relay);
      tick(30);
      chk("out_relay", 2'h2, out_relay);
      wr(REG_INFN, 32'hA0);
      fire(2'h1);
      hold(1, 1'b1);
      chk("out_relay", 2'h0, out_relay);
      fire(2'h3);
      tick(3);
      chk("out_relay", 2'h3, out_relay);
      hold(1, 1'b0);
      wr(REG_CTRL, 32'hCC0A);
      tick(40);
      chk("annun_relay", 4'hB, {out_annun, out_relay});
      fire(2'h1);
      tick(3);
      chk("out_relay", 2'h2, out_relay);
      tick(40);
      chk("out_relay", 2'h3, out_relay);
      wr(REG_CTRL, 32'hCC01);
      wr(REG_TIME0, 32'h2);
      fire(2'h1);
      tick(90);
      chk("out_relay", 2'h3, out_relay);
      tick(130);
      chk("out_relay", 2'h2, out_relay);
      wr(REG_INFN, 32'h4);
      hold(0, 1'b1);
      fire(2'h3);
      tick(3);
      chk("out_relay", 2'h0, out_relay);
      hold(0, 1'b0);
      wr(REG_INFN, 32'h7);
      for (int j = 0; j < 3; j++) begin
         wr(REG_CODE, 32'(code_tab[j]));
         hold(0, 1'b1);
         code_in(8'h01);
         code_in(code_tab[j]);
         chk("menu_access", acc_tab[j], menu_access);
         chk("code_entry_offered", j > 0, code_entry_offered);
         hold(0, 1'b0);
      end
      chk("menu_access", ACC_OPEN, menu_access);
      wr(REG_INFN, 32'h6000);
      d = next_display_value;
      hold(3, 1'b1);
      chk("next_display_value", DISP_W'((d + 1) % DISP_VALUES_DEF), next_display_value);
      hold(3, 1'b0);
      wr(REG_CTRL, 32'hCE00);
      d = next_display_value;
      tick(2450);
      chk("next_display_value", d, next_display_value);
      tick(100);
      chk("next_display_value", DISP_W'((d + 1) % DISP_VALUES_DEF), next_display_value);
      for (int b = 0; b < 4; b++) begin
         wr(REG_CTRL, 32'hC000 | (b << 10) | ((b % 3) << 12));
         repeat (3) gap(n);
         chk("baud gap", 96000 / rate_tab[b], n);
         chk("serial format", fmt_tab[b % 3], {serial_data_8, serial_parity_en, serial_parity_odd});
      end
      close_out();
   end
endmodule
bind tmc_out_uin_ctrl tmc_props #(.DISP_VALUES(DISP_VALUES)) prop_u (.*);
`default_nettype wire
